// [inc/sensor_mode_pkg.sv]
// constants, types and helpers shared by the mode controller
package sensor_mode_pkg;
   // ----------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      m_standby, m_sleep, m_wake_sleep, m_continuous
   } mode_t;

   localparam logic [1:0] MODE_STANDBY    = 2'h0;
   localparam logic [1:0] MODE_SLEEP      = 2'h1;
   localparam logic [1:0] MODE_WAKE_SLEEP = 2'h2;
   localparam logic [1:0] MODE_CONTINUOUS = 2'h3;

   // ----------------------------------------------------------
   // internal configuration register
   // ----------------------------------------------------------
   localparam logic [6:0] MODE_REG_ADDR   = 7'h01;
   localparam int         MODE_LSB        = 0;
   localparam int         WAKE_SEL_LSB    = 4;
   localparam logic [1:0] MODE_RESET      = 2'h0;
   localparam logic [3:0] WAKE_SEL_RESET  = 4'h0;

   // ----------------------------------------------------------
   // bus constants
   // ----------------------------------------------------------
   localparam logic [7:0] GCALL_BYTE      = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam logic [6:0] DEV_ADDR_DEF    = 7'h2A; // arbitrary

   // ----------------------------------------------------------
   // timing
   // ----------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

   // wake interval in milliseconds per selector
   function automatic logic [15:0] wake_ms(input logic [3:0] sel);
      case (sel)
         4'h0:    wake_ms = 16'h0001;
         4'h1:    wake_ms = 16'h0005;
         4'h2:    wake_ms = 16'h000A;
         4'h3:    wake_ms = 16'h000F;
         4'h4:    wake_ms = 16'h0014;
         4'h5:    wake_ms = 16'h001E;
         4'h6:    wake_ms = 16'h0032;
         4'h7:    wake_ms = 16'h0064;
         4'h8:    wake_ms = 16'h01F4;
         4'h9:    wake_ms = 16'h03E8;
         4'hA:    wake_ms = 16'h07D0;
         4'hB:    wake_ms = 16'h1388;
         default: wake_ms = 16'h4E20;
      endcase
   endfunction

   function automatic mode_t to_mode(input logic [1:0] code);
      case (code)
         MODE_SLEEP:      to_mode = m_sleep;
         MODE_WAKE_SLEEP: to_mode = m_wake_sleep;
         MODE_CONTINUOUS: to_mode = m_continuous;
         default:         to_mode = m_standby;
      endcase
   endfunction
endpackage

// [src/wake_timer.sv]
// millisecond interval timer for wake-and-sleep
`timescale 1ns/100ps
module wake_timer
   import sensor_mode_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        run,
   input  wire logic [15:0] interval_ms,
   output logic             expire
);
   logic [31:0] tick_cnt;
   logic [15:0] ms_cnt;
   logic        ms_tick;

   assign ms_tick = (tick_cnt == 32'(MS_CYCLES - 1));

   // ----------------------------------------------------------
   // counters restart whenever the mode is left
   // ----------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt <= 32'h0;
      end else if (!run || ms_tick) begin
         tick_cnt <= 32'h0;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ms_cnt <= 16'h0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (!run) begin
            ms_cnt <= 16'h0;
         end else if (ms_tick) begin
            if (ms_cnt >= interval_ms - 16'h1) begin
               ms_cnt <= 16'h0;
               expire <= 1'b1;
            end else begin
               ms_cnt <= ms_cnt + 16'h1;
            end
         end
      end
   end
endmodule

// [src/sensor_mode_ctrl_i2c_write.sv]
// operating-mode controller and i2c write-frame receiver
`timescale 1ns/100ps
module sensor_mode_ctrl_i2c_write
   import sensor_mode_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [6:0] dev_addr,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       int_n_in,
   output logic            int_n_out,
   output logic            int_n_oe,
   input  wire logic       int_latch_en,
   input  wire logic       int_event,
   input  wire logic       conv_done,
   input  wire logic       int_cond_met,
   output logic            conv_start,
   output logic            result_store,
   output logic            result_clear,
   output logic [1:0]      op_mode,
   output logic [3:0]      wake_interval_sel,
   output logic            user_access,
   output logic            reg_wr,
   output logic [6:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------
   logic [2:0] scl_s;
   logic [2:0] sda_s;
   logic [2:0] int_s;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         int_s <= 3'h7;
      end else begin
         scl_s <= {scl_s[1:0], scl_in};
         sda_s <= {sda_s[1:0], sda_in};
         int_s <= {int_s[1:0], int_n_in};
      end
   end

   // only stages 1 and 2 are looked at
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic int_edge;

   assign scl_rise  = scl_s[1] & ~scl_s[2];
   assign scl_fall  = ~scl_s[1] & scl_s[2];
   assign bus_start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   assign bus_stop  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
   // own drive of the pin is not a trigger
   assign int_edge  = int_s[2] & ~int_s[1] & ~int_n_oe;

   // ----------------------------------------------------------
   // i2c write-frame receiver
   // ----------------------------------------------------------
   typedef enum logic [1:0] {b_idle, b_addr, b_cmd, b_data} bus_t;

   bus_t       bstate;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic       ack_phase;
   logic [6:0] ptr;
   logic       byte_end;
   logic       addr_hit;
   logic       cmd_trig;
   logic       gcall;
   logic       own_hit;

   assign byte_end = scl_fall & ~ack_phase & (bit_cnt == BITS_PER_BYTE)
                   & (bstate != b_idle);
   assign gcall    = (shreg == GCALL_BYTE);
   assign own_hit  = (shreg[7:1] == dev_addr);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bstate    <= b_idle;
         bit_cnt   <= 4'h0;
         shreg     <= 8'h00;
         ack_phase <= 1'b0;
         sda_oe    <= 1'b0;
      end else if (bus_start) begin
         bstate    <= b_addr;
         bit_cnt   <= 4'h0;
         ack_phase <= 1'b0;
         sda_oe    <= 1'b0;
      end else if (bus_stop) begin
         bstate    <= b_idle;
         ack_phase <= 1'b0;
         sda_oe    <= 1'b0;
      end else if (scl_rise && !ack_phase && bstate != b_idle) begin
         shreg   <= {shreg[6:0], sda_s[2]};
         bit_cnt <= bit_cnt + 4'h1;
      end else if (byte_end) begin
         bit_cnt   <= 4'h0;
         ack_phase <= 1'b1;
         case (bstate)
            b_addr: begin
               if (gcall || (own_hit && !shreg[0])) begin
                  bstate <= b_cmd;
                  sda_oe <= 1'b1;
               end else begin
                  bstate <= b_idle;
               end
            end
            b_cmd: begin
               bstate <= b_data;
               sda_oe <= 1'b1;
            end
            b_data: begin
               sda_oe <= 1'b1;
            end
            default: begin
               bstate <= b_idle;
            end
         endcase
      end else if (scl_fall && ack_phase) begin
         ack_phase <= 1'b0;
         sda_oe    <= 1'b0;
      end
   end

   // ack is a pull low only
   assign sda_out = 1'b0;

   // address pointer, trigger and write strobe
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr       <= 7'h00;
         reg_wr    <= 1'b0;
         reg_addr  <= 7'h00;
         reg_wdata <= 8'h00;
         cmd_trig  <= 1'b0;
         addr_hit  <= 1'b0;
      end else begin
         reg_wr   <= 1'b0;
         cmd_trig <= 1'b0;
         addr_hit <= 1'b0;
         if (byte_end) begin
            case (bstate)
               b_addr: begin
                  addr_hit <= gcall | own_hit;
               end
               b_cmd: begin
                  ptr      <= shreg[6:0];
                  cmd_trig <= shreg[7];
               end
               b_data: begin
                  reg_wr    <= 1'b1;
                  reg_addr  <= ptr;
                  reg_wdata <= shreg;
                  ptr       <= ptr + 7'h1;
               end
               default: begin
                  ptr <= ptr;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------
   // configuration kept in every mode
   // ----------------------------------------------------------
   logic [1:0] cfg_mode;
   logic       cfg_wr;

   // writes reach the user registers only when open
   assign cfg_wr = reg_wr & user_access & (reg_addr == MODE_REG_ADDR);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_mode          <= MODE_RESET;
         wake_interval_sel <= WAKE_SEL_RESET;
      end else if (cfg_wr) begin
         cfg_mode          <= reg_wdata[MODE_LSB +: 2];
         wake_interval_sel <= reg_wdata[WAKE_SEL_LSB +: 4];
      end
   end

   // ----------------------------------------------------------
   // operating mode machine
   // ----------------------------------------------------------
   mode_t mode;
   mode_t next_mode;
   logic  wake_req;
   logic  tmr_expire;
   logic  cont_kick;

   assign wake_req = addr_hit | int_edge;

   always_comb begin
      next_mode = mode;
      case (mode)
         m_standby: begin
            if (cfg_wr) begin
               next_mode = to_mode(reg_wdata[MODE_LSB +: 2]);
            end
         end
         m_continuous: begin
            if (cfg_wr) begin
               next_mode = to_mode(reg_wdata[MODE_LSB +: 2]);
            end
         end
         m_sleep: begin
            if (wake_req) begin
               next_mode = m_standby;
            end
         end
         m_wake_sleep: begin
            if (wake_req) begin
               next_mode = m_standby;
            end else if (conv_done && int_cond_met) begin
               next_mode = m_standby;
            end
         end
         default: begin
            next_mode = m_standby;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode         <= m_standby;
         op_mode      <= MODE_STANDBY;
         result_clear <= 1'b0;
         cont_kick    <= 1'b0;
      end else begin
         mode         <= next_mode;
         result_clear <= (next_mode == m_sleep) & (mode != m_sleep);
         cont_kick    <= (next_mode == m_continuous)
                       && (mode != m_continuous);
         case (next_mode)
            m_sleep:      op_mode <= MODE_SLEEP;
            m_wake_sleep: op_mode <= MODE_WAKE_SLEEP;
            m_continuous: op_mode <= MODE_CONTINUOUS;
            default:      op_mode <= MODE_STANDBY;
         endcase
      end
   end

   assign user_access = (mode == m_standby) | (mode == m_continuous);

   // ----------------------------------------------------------
   // conversion control and result handling
   // ----------------------------------------------------------
   wake_timer #(
      .MS_CYCLES  (MS_CYCLES)
   ) u_wake_timer (
      .ref_clk     (ref_clk),
      .reset_n     (reset_n),
      .run         (mode == m_wake_sleep),
      .interval_ms (wake_ms(wake_interval_sel)),
      .expire      (tmr_expire)
   );

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         conv_start   <= 1'b0;
         result_store <= 1'b0;
      end else begin
         case (mode)
            m_standby: begin
               conv_start   <= cmd_trig | int_edge;
               result_store <= conv_done;
            end
            m_wake_sleep: begin
               conv_start   <= tmr_expire;
               result_store <= conv_done & int_cond_met;
            end
            m_continuous: begin
               // restart off each finish keeps the sensor busy
               conv_start   <= cont_kick | conv_done;
               result_store <= conv_done;
            end
            default: begin
               conv_start   <= 1'b0;
               result_store <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // latched interrupt pin
   // ----------------------------------------------------------
   logic int_latch;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_latch <= 1'b0;
      end else if (int_event && int_latch_en) begin
         int_latch <= 1'b1;
      end else if (addr_hit) begin
         int_latch <= 1'b0;
      end
   end

   assign int_n_oe  = int_latch;
   assign int_n_out = 1'b0;

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   chk_sleep_wake: assert property (
      (mode == m_sleep && addr_hit) |=> op_mode == MODE_STANDBY)
      else $error("sleep not left on address");
   chk_ws_wake: assert property (
      (mode == m_wake_sleep && int_edge) |=> mode == m_standby)
      else $error("wake-sleep not left on pin");
   chk_ws_exit: assert property (
      (mode == m_wake_sleep && conv_done && int_cond_met)
      |=> result_store && mode == m_standby)
      else $error("wake-sleep hit not stored");
   chk_ws_stay: assert property (
      (mode == m_wake_sleep && conv_done && !int_cond_met
       && !wake_req) |=> mode == m_wake_sleep && !result_store)
      else $error("wake-sleep left on miss");
   chk_trig_start: assert property (
      (mode == m_standby && cmd_trig) |=> conv_start)
      else $error("trigger bit lost");
   chk_gcall_ack: assert property (
      (byte_end && bstate == b_addr && gcall) |=> sda_oe ##1 bstate == b_cmd)
      else $error("general call not acked");
   chk_wr_incr: assert property (
      (byte_end && bstate == b_data)
      |=> reg_wr && reg_addr == $past(ptr) && ptr == $past(ptr) + 7'h1)
      else $error("write pointer wrong");
   chk_latch_hold: assert property (
      (int_latch && !addr_hit) |=> int_n_oe)
      else $error("latched interrupt dropped");
   chk_sleep_clear: assert property (
      (mode != m_sleep ##1 mode == m_sleep) |-> result_clear)
      else $error("results kept into sleep");
   chk_mode_sel: assert property (
      (cfg_wr && mode == m_standby)
      |=> op_mode == $past(reg_wdata[1:0]))
      else $error("mode field ignored");

   cov_ws_exit:   cover property (mode == m_wake_sleep ##1 mode == m_standby);
   cov_gcall_wr:  cover property (addr_hit && gcall ##[1:400] reg_wr);
   cov_sleep_pin: cover property (mode == m_sleep && int_edge);
   cov_cont_run:  cover property (mode == m_continuous && conv_start);
endmodule

// [testbench/i2c_primary_model.sv]
// i2c bus primary model: open-drain scl/sda driver with start/stop/byte
`timescale 1ns/100ps
module i2c_primary_model (
   input  wire logic ref_clk,
   input  wire logic sda,
   output logic      scl_drv,
   output logic      sda_drv
);
   // -------------------------------------------------------------
   // bus idles released, scl stands high outside frames
   // -------------------------------------------------------------
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // also serves as repeated start when scl is low
   task automatic start_cond;
      sda_drv = 1'b1;
      wait_clk(4);
      scl_drv = 1'b1;
      wait_clk(4);
      sda_drv = 1'b0;
      wait_clk(4);
      scl_drv = 1'b0;
      wait_clk(4);
   endtask

   task automatic stop_cond;
      sda_drv = 1'b0;
      wait_clk(4);
      scl_drv = 1'b1;
      wait_clk(4);
      sda_drv = 1'b1;
      wait_clk(8);
   endtask

   // msb first, sda only changes while scl is low
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_drv = b[i];
         wait_clk(4);
         scl_drv = 1'b1;
         wait_clk(8);
         scl_drv = 1'b0;
         wait_clk(4);
      end
      sda_drv = 1'b1;
      wait_clk(4);
      scl_drv = 1'b1;
      wait_clk(4);
      ack = ~sda;
      wait_clk(4);
      scl_drv = 1'b0;
      wait_clk(4);
   endtask
endmodule

// [testbench/test_sensor_mode_ctrl_i2c_write.sv]
// self-checking bench for the mode controller and i2c write receiver
`timescale 1ns/100ps
module test_sensor_mode_ctrl_i2c_write;
   import sensor_mode_pkg::*;
   localparam int MSC = 2;
   logic ref_clk, reset_n, int_latch_en, int_event, conv_done;
   logic int_cond_met, int_pull, sda_out, sda_oe, int_n_out, int_n_oe;
   logic conv_start, result_store, result_clear, user_access, reg_wr;
   logic [1:0] op_mode, last_mode;
   logic [3:0] wake_interval_sel;
   logic [6:0] dev_addr, reg_addr, ptr;
   logic [7:0] reg_wdata, own_w;
   logic [7:0] wdat [4];
   logic [6:0] qa [$];
   logic [7:0] qd [$];
   wire logic  scl_drv, sda_drv;
   int err_total, n_checks, n_start, n_store, n_clear;
   int cyc, t_ws, first_cs, acks, s0, st, cl, d;
   integer seed;
   // open-drain lines with pull-ups
   wire logic sda_w = sda_drv & ~(sda_oe & ~sda_out);
   wire logic int_w = ~int_pull & ~(int_n_oe & ~int_n_out);

   i2c_primary_model mst (.ref_clk(ref_clk), .sda(sda_w),
      .scl_drv(scl_drv), .sda_drv(sda_drv));
   sensor_mode_ctrl_i2c_write #(.MS_CYCLES(MSC)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .dev_addr(dev_addr),
      .scl_in(scl_drv), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .int_n_in(int_w), .int_n_out(int_n_out),
      .int_n_oe(int_n_oe), .int_latch_en(int_latch_en),
      .int_event(int_event), .conv_done(conv_done),
      .int_cond_met(int_cond_met), .conv_start(conv_start),
      .result_store(result_store), .result_clear(result_clear),
      .op_mode(op_mode), .wake_interval_sel(wake_interval_sel),
      .user_access(user_access), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata));

   always #5 ref_clk = ~ref_clk;

   // -------------------------------------------------------------
   // monitor: pulses are single cycle, so count them at every edge
   // -------------------------------------------------------------
   always @(posedge ref_clk) begin
      cyc++;
      if (reset_n === 1'b1) begin
         if (op_mode === MODE_WAKE_SLEEP && last_mode !== MODE_WAKE_SLEEP)
         begin
            t_ws = cyc;
            first_cs = -1;
         end
         if (conv_start === 1'b1) begin
            n_start++;
            if (first_cs < 0) first_cs = cyc;
         end
         if (result_store === 1'b1) n_store++;
         if (result_clear === 1'b1) n_clear++;
         if (reg_wr === 1'b1) begin
            qa.push_back(reg_addr);
            qd.push_back(reg_wdata);
         end
      end
      last_mode = op_mode;
   end

   function automatic int exp_ms(input int sel);
      int t [13] = '{1, 5, 10, 15, 20, 30, 50, 100, 500, 1000, 2000,
                     5000, 20000};
      exp_ms = t[sel];
   endfunction

   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t: %s got %0h expected %0h", $time, what,
                  seen, exp);
      end
   endtask

   // n < 0 sends the first byte only
   task automatic frame(input logic [7:0] first, input logic [7:0] cmd,
                        input int n, output int a);
      logic ack;
      a = 0;
      mst.start_cond();
      mst.send_byte(first, ack);
      a += (ack === 1'b1);
      if (n >= 0) begin
         mst.send_byte(cmd, ack);
         a += (ack === 1'b1);
         for (int i = 0; i < n; i++) begin
            mst.send_byte(wdat[i], ack);
            a += (ack === 1'b1);
         end
      end
      mst.stop_cond();
   endtask

   task automatic set_cfg(input logic [7:0] v);
      int a;
      wdat[0] = v;
      frame(own_w, {1'b0, MODE_REG_ADDR}, 1, a);
      check(a, 3, "cfg acks");
      wait_clk(3);
   endtask

   task automatic pulse_done(input logic cond);
      conv_done = 1'b1;
      int_cond_met = cond;
      wait_clk(1);
      conv_done = 1'b0;
      int_cond_met = 1'b0;
   endtask

   task automatic wait_start(input int s, input int lim);
      int k;
      k = 0;
      while (n_start == s && k < lim) begin
         wait_clk(1);
         k++;
      end
      check(n_start > s, 1, "conv_start missing");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      // whole run is about 70000 cycles, so this leaves margin
      #950000;
      err_total++;
      $display("ERROR at %0t: watchdog expired", $time);
      test_done;
   end

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      seed = 32'hFB40F3DA;
      {ref_clk, reset_n, int_latch_en, int_event} = 4'h0;
      {conv_done, int_cond_met, int_pull} = 3'h0;
      {err_total, n_checks, n_start, n_store, n_clear, cyc} = '0;
      t_ws = 0;
      first_cs = 0;
      dev_addr = 7'($random(seed)) | 7'h01;
      own_w = {dev_addr, 1'b0};
      wait_clk(5);
      reset_n = 1'b1;
      wait_clk(4);
      check(op_mode, MODE_STANDBY, "reset mode");
      check(user_access, 1, "reset access");
      check(wake_interval_sel, WAKE_SEL_RESET, "reset sel");
      $display("test reset done");
      for (int t = 0; t < 2; t++) begin
         ptr = (t == 0) ? 7'h7E : 7'h10 + 7'($random(seed) & 32'h3F);
         for (int i = 0; i < 3; i++) wdat[i] = 8'($random(seed));
         s0 = n_start;
         qa.delete();
         qd.delete();
         frame(own_w, {1'b1, ptr}, 3, acks);
         check(acks, 5, "write acks");
         check(n_start - s0, 1, "cmd trigger");
         check(qa.size(), 3, "write count");
         for (int i = 0; i < 3 && i < qa.size(); i++) begin
            check(qa[i], 7'(ptr + i), "write addr");
            check(qd[i], wdat[i], "write data");
         end
      end
      $display("test write frames done");
      s0 = n_start;
      int_pull = 1'b1;
      wait_clk(10);
      int_pull = 1'b0;
      wait_clk(6);
      check(n_start - s0, 1, "pin trigger");
      st = n_store;
      cl = n_clear;
      pulse_done(1'b0);
      wait_clk(53);
      check(n_store - st, 1, "standby store");
      check(n_clear - cl, 0, "standby clear");
      $display("test standby done");
      s0 = n_start;
      wdat[0] = {4'h3, 2'h0, MODE_CONTINUOUS};
      frame(GCALL_BYTE, {1'b0, MODE_REG_ADDR}, 1, acks);
      wait_clk(4);
      check(acks, 3, "gcall acks");
      check(op_mode, MODE_CONTINUOUS, "gcall mode");
      check(wake_interval_sel, 4'h3, "gcall sel");
      check(user_access, 1, "cont access");
      check(n_start - s0, 1, "cont kick");
      st = n_store;
      s0 = n_start;
      pulse_done(1'b0);
      wait_clk(3);
      check(n_store - st, 1, "cont store");
      check(n_start - s0, 1, "cont restart");
      set_cfg({4'h3, 2'h0, MODE_STANDBY});
      check(op_mode, MODE_STANDBY, "cont to standby");
      check(user_access, 1, "standby access");
      $display("test continuous done");
      for (int k = 0; k < 2; k++) begin
         cl = n_clear;
         set_cfg({4'h5, 2'h0, MODE_SLEEP});
         check(op_mode, MODE_SLEEP, "sleep mode");
         check(n_clear - cl, 1, "sleep clear");
         check(user_access, 0, "sleep access");
         s0 = n_start;
         if (k == 0) begin
            int_pull = 1'b1;
            wait_clk(6);
            int_pull = 1'b0;
         end else begin
            frame(own_w, 8'h00, -1, acks);
            check(acks, 1, "addr ack");
         end
         wait_clk(2);
         check(op_mode, MODE_STANDBY, "sleep wake");
         check(n_start - s0, 0, "wake no conv");
         check(wake_interval_sel, 4'h5, "sleep keeps sel");
      end
      $display("test sleep done");
      for (int sel = 0; sel < 13; sel++) begin
         s0 = n_start;
         set_cfg({4'(sel), 2'h0, MODE_WAKE_SLEEP});
         check(user_access, 0, "ws access");
         wait_start(s0, exp_ms(sel) * MSC + 40);
         d = first_cs - t_ws - exp_ms(sel) * MSC;
         check(d >= -1 && d <= 3, 1, "ws interval");
         if (sel < 4) begin
            st = n_store;
            s0 = n_start;
            pulse_done(1'b0);
            wait_clk(2);
            check(op_mode, MODE_WAKE_SLEEP, "ws miss mode");
            check(n_store - st, 0, "ws miss store");
            wait_start(s0, exp_ms(sel) * MSC + 40);
         end
         st = n_store;
         pulse_done(1'b1);
         wait_clk(2);
         check(op_mode, MODE_STANDBY, "ws hit mode");
         check(n_store - st, 1, "ws hit store");
      end
      $display("test wake-sleep done");
      for (int k = 0; k < 2; k++) begin
         s0 = n_start;
         set_cfg({4'hC, 2'h0, MODE_WAKE_SLEEP});
         wait_clk(50);
         if (k == 0) begin
            int_pull = 1'b1;
            wait_clk(6);
            int_pull = 1'b0;
         end else
            frame(own_w, 8'h00, -1, acks);
         wait_clk(2);
         check(op_mode, MODE_STANDBY, "ws exit");
         check(n_start - s0, 0, "ws exit no conv");
      end
      $display("test wake-sleep exit done");
      int_latch_en = 1'b1;
      int_event = 1'b1;
      wait_clk(1);
      int_event = 1'b0;
      s0 = n_start;
      wait_clk(32);
      check(int_n_oe, 1, "latch set");
      frame({dev_addr ^ 7'h40, 1'b0}, 8'h00, -1, acks);
      check(acks, 0, "foreign refused");
      check(int_n_oe, 1, "latch held");
      frame(own_w, 8'h00, -1, acks);
      wait_clk(2);
      check(int_n_oe, 0, "latch cleared");
      check(n_start - s0, 0, "latch no conv");
      $display("test latch done");
      test_done;
   end
endmodule
